// ==== tba_arbiter.sv ====
// processor end of the three-wire arbitration link: arbiter and bus float control
`timescale 1ns/1ps
`default_nettype none
module tba_arbiter #(
    parameter int SYNC_STAGES = tba_pkg::SYNC_STAGES
) (
    input wire logic clock_in,           // processor clock
    input wire logic reset_in,           // synchronous, active high
    input wire logic clock_enable_in,    // freezes state when low
    input wire logic cycle_pending_in,   // bus controller decided to run a cycle
    input wire logic cycle_active_in,    // processor bus cycle in progress
    input wire logic locked_active_in,   // locked read-modify-write running
    output logic bus_float_out,          // address, data, control floated
    output logic cycle_allowed_out,      // processor may start a bus cycle
    tba_link_if.device link              // link to alternate masters
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [SYNC_STAGES-1:0] req_sync_q, req_sync_d;
    logic [SYNC_STAGES-1:0] ack_sync_q, ack_sync_d;
    logic req, ack;

    // pins enter the low end; only the last stage feeds the arbiter
    function automatic logic [SYNC_STAGES-1:0] sync_shift(
        input logic [SYNC_STAGES-1:0] chain,
        input logic pin_asserted
    );
        sync_shift = {chain[SYNC_STAGES-2:0], pin_asserted};
    endfunction

    always_comb begin
        req_sync_d = sync_shift(req_sync_q, !link.bus_request_n);
        ack_sync_d = sync_shift(ack_sync_q, !link.grant_acknowledge_n);
    end

    // both chains clear to the negated level, so no false request follows reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            req_sync_q <= '0;
            ack_sync_q <= '0;
        end else if (clock_enable_in) begin
            req_sync_q <= req_sync_d;
            ack_sync_q <= ack_sync_d;
        end
    end

    assign req = req_sync_q[SYNC_STAGES-1];
    assign ack = ack_sync_q[SYNC_STAGES-1];

    // ---------------------------------------------------------------
    // arbiter state machine
    // ---------------------------------------------------------------
    tba_pkg::tba_arb_state_t state_q, state_d;
    logic grant_q, grant_d;
    logic float_q, float_d;
    logic hold_off;
    logic tri_ctl;

    // ---------------------------------------------------------------
    // state decoding
    // ---------------------------------------------------------------
    // grant is shown only in the two granting states
    function automatic logic grant_of(input tba_pkg::tba_arb_state_t s);
        case (s)
            tba_pkg::TBA_GRANT: begin
                grant_of = 1'b1;
            end
            tba_pkg::TBA_GRANT_HOLD: begin
                grant_of = 1'b1;
            end
            default: begin
                grant_of = 1'b0;
            end
        endcase
    endfunction

    // only idle leaves the buses to the processor
    function automatic logic tri_of(input tba_pkg::tba_arb_state_t s);
        case (s)
            tba_pkg::TBA_IDLE: begin
                tri_of = 1'b0;
            end
            default: begin
                tri_of = 1'b1;
            end
        endcase
    endfunction

    // reset, halt and double-fault states do not gate anything here
    // a decided cycle must start, and a locked sequence must end, first
    assign hold_off = locked_active_in || !link.locked_cycle_n
                      || (cycle_pending_in && !cycle_active_in);

    always_comb begin
        state_d = state_q;
        case (state_q)
            tba_pkg::TBA_IDLE: begin
                if (req && !hold_off) begin
                    state_d = tba_pkg::TBA_GRANT;
                end else if (ack) begin
                    state_d = tba_pkg::TBA_FLOAT;
                end
            end
            tba_pkg::TBA_GRANT: begin
                state_d = tba_pkg::TBA_GRANT_HOLD;
            end
            tba_pkg::TBA_GRANT_HOLD: begin
                if (ack || !req) begin
                    state_d = tba_pkg::TBA_GRANT_DROP;
                end
            end
            tba_pkg::TBA_GRANT_DROP: begin
                state_d = tba_pkg::TBA_FLOAT;
            end
            tba_pkg::TBA_FLOAT: begin
                if (req && ack) begin
                    state_d = tba_pkg::TBA_GRANT;
                end else if (!ack) begin
                    state_d = tba_pkg::TBA_IDLE;
                end
            end
            default: begin
                state_d = tba_pkg::TBA_IDLE;
            end
        endcase
    end

    assign tri_ctl = tri_of(state_q);

    always_comb begin
        // grant mirrors the state's g value; its pin register lags a half clock
        // a lock masks the pin even if the state machine is mid-grant
        grant_d = grant_of(state_q) && link.locked_cycle_n;
        // floating waits for strobe and lock to drop; return is immediate
        if (!tri_ctl) begin
            float_d = 1'b0;
        end else if (link.address_strobe_n && link.locked_cycle_n) begin
            float_d = 1'b1;
        end else begin
            float_d = float_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q <= tba_pkg::TBA_IDLE;
        end else if (clock_enable_in) begin
            state_q <= state_d;
        end
    end

    // float waits on the strobe as well as the state, so a late cycle ends driven
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            float_q <= 1'b0;
        end else if (clock_enable_in) begin
            float_q <= float_d;
        end
    end

    // grant pin updates on the falling edge after the state is reached
    always_ff @(negedge clock_in) begin
        if (reset_in) begin
            grant_q <= 1'b0;
        end else if (clock_enable_in) begin
            grant_q <= grant_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign link.bus_grant_n = !grant_q;
    assign link.address_strobe_n = !cycle_active_in;
    assign link.locked_cycle_n = !locked_active_in;
    assign bus_float_out = float_q;
    // no processor cycle while arbitration owns the bus or regrants
    assign cycle_allowed_out = !tri_ctl;
endmodule
`default_nettype wire

// ==== tba_pkg.sv ====
// shared constants and types for the three-wire bus arbitration ends
package tba_pkg;
    // ---------------------------------------------------------------
    // timing and sizing
    // ---------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam logic RESET_LEVEL_N = 1'b1;
    localparam int CLOCK_PERIOD_NS = 100;

    // ---------------------------------------------------------------
    // arbiter and master states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        TBA_IDLE,
        TBA_GRANT,
        TBA_GRANT_HOLD,
        TBA_GRANT_DROP,
        TBA_FLOAT
    } tba_arb_state_t;

    typedef enum logic [1:0] {
        TBA_M_IDLE,
        TBA_M_WAIT_GRANT,
        TBA_M_WAIT_FREE,
        TBA_M_OWNER
    } tba_master_state_t;
endpackage

// ==== tba_link_if.sv ====
// link between the processor arbiter and one alternate bus master
`timescale 1ns/1ps
`default_nettype none
interface tba_link_if;
    logic bus_request_n;
    logic bus_grant_n;
    logic grant_acknowledge_n;
    logic address_strobe_n;
    logic cycle_termination_ack_n;
    logic locked_cycle_n;
    logic bus_fault_n;

    modport device (
        input bus_request_n,
        output bus_grant_n,
        input grant_acknowledge_n,
        output address_strobe_n,
        input cycle_termination_ack_n,
        output locked_cycle_n,
        input bus_fault_n
    );
    modport master (
        output bus_request_n,
        input bus_grant_n,
        output grant_acknowledge_n,
        input address_strobe_n,
        input cycle_termination_ack_n,
        input locked_cycle_n,
        output bus_fault_n
    );
endinterface
`default_nettype wire

// ==== tba_master.sv ====
// alternate bus master end of the three-wire arbitration link
`timescale 1ns/1ps
`default_nettype none
module tba_master (
    input wire logic clock_in,           // system clock
    input wire logic reset_in,           // synchronous, active high
    input wire logic clock_enable_in,    // freezes state when low
    input wire logic need_bus_in,        // user wants the bus
    input wire logic work_done_in,       // all needed cycles complete
    input wire logic priority_won_in,    // external priority arbitration result
    input wire logic abort_locked_in,    // break a locked sequence
    input wire logic check_term_in,      // also wait for termination ack
    output logic owner_out,              // this master owns the bus
    tba_link_if.master link              // link to the processor
);
    tba_pkg::tba_master_state_t state_q, state_d;
    logic fault_q, fault_d;

    // ---------------------------------------------------------------
    // master state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        fault_d = 1'b0;
        case (state_q)
            tba_pkg::TBA_M_IDLE: begin
                if (need_bus_in) begin
                    state_d = tba_pkg::TBA_M_WAIT_GRANT;
                end
            end
            tba_pkg::TBA_M_WAIT_GRANT: begin
                // a locked sequence never yields; break it with a bus fault
                fault_d = abort_locked_in && !link.locked_cycle_n;
                if (!need_bus_in) begin
                    state_d = tba_pkg::TBA_M_IDLE;
                end else if (!link.bus_grant_n && priority_won_in) begin
                    state_d = tba_pkg::TBA_M_WAIT_FREE;
                end
            end
            tba_pkg::TBA_M_WAIT_FREE: begin
                if (link.address_strobe_n && link.grant_acknowledge_n
                    && (link.cycle_termination_ack_n || !check_term_in)) begin
                    state_d = tba_pkg::TBA_M_OWNER;
                end
            end
            tba_pkg::TBA_M_OWNER: begin
                if (work_done_in) begin
                    state_d = tba_pkg::TBA_M_IDLE;
                end
            end
            default: begin
                state_d = tba_pkg::TBA_M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q <= tba_pkg::TBA_M_IDLE;
            fault_q <= 1'b0;
        end else if (clock_enable_in) begin
            state_q <= state_d;
            fault_q <= fault_d;
        end
    end

    // request drops once acknowledge is driven
    assign link.bus_request_n = !(state_q == tba_pkg::TBA_M_WAIT_GRANT
                                  || state_q == tba_pkg::TBA_M_WAIT_FREE);
    assign link.grant_acknowledge_n = !(state_q == tba_pkg::TBA_M_OWNER);
    assign link.bus_fault_n = !fault_q;
    assign owner_out = (state_q == tba_pkg::TBA_M_OWNER);
endmodule
`default_nettype wire

// ==== tba_link_asserts.sv ====
// concurrent checks on the arbitration link signals
`timescale 1ns/1ps
`default_nettype none
module tba_link_asserts (
    input wire logic clock_in, // clock
    input wire logic reset_in, // sync reset
    input wire logic bus_request_n, // request
    input wire logic bus_grant_n, // grant
    input wire logic grant_acknowledge_n, // acknowledge
    input wire logic address_strobe_n, // strobe
    input wire logic cycle_termination_ack_n, // termination
    input wire logic locked_cycle_n, // lock
    input wire logic bus_fault_n // fault
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic grant_pos_q;
    always_ff @(posedge clock_in) begin
        grant_pos_q <= bus_grant_n;
    end
    a_grant_after_req: assert property ($fell(bus_request_n) ##0
        (!bus_request_n && locked_cycle_n)[*4] |-> ##[0:6] !bus_grant_n)
        else $error("grant late after request");
    a_lock_no_grant: assert property (!locked_cycle_n |-> bus_grant_n)
        else $error("grant during locked cycle");
    a_ack_drops_grant: assert property ($fell(grant_acknowledge_n) |-> ##[1:5] bus_grant_n)
        else $error("grant kept after acknowledge");
    a_idle_holds: assert property (
        (bus_request_n && grant_acknowledge_n && bus_grant_n)[*3] |=> bus_grant_n)
        else $error("grant without request");
    a_withdraw_release: assert property (
        !bus_grant_n && $rose(bus_request_n) && grant_acknowledge_n |-> ##[1:5] bus_grant_n)
        else $error("grant kept after withdrawal");
    a_fault_one_cycle: assert property ($fell(bus_fault_n) |=> bus_fault_n)
        else $error("fault pulse too long");
    a_ack_when_free: assert property ($fell(grant_acknowledge_n) |->
        $past(address_strobe_n && cycle_termination_ack_n) && $past(!bus_grant_n, 2))
        else $error("acknowledge while bus busy");
    a_req_with_ack: assert property ($fell(grant_acknowledge_n) |-> bus_request_n)
        else $error("request kept after acknowledge");
    a_grant_on_fall: assert property (@(negedge clock_in) disable iff (reset_in)
        bus_grant_n == grant_pos_q)
        else $error("grant moved off the falling edge");
    cover property ($fell(bus_grant_n));
    cover property ($fell(grant_acknowledge_n));
    cover property ($fell(bus_fault_n));
endmodule
`default_nettype wire

// ==== three_wire_bus_arbitration_tb.sv ====
// self-checking bench for the three-wire arbitration link
`timescale 1ns/1ps
`default_nettype none
module three_wire_bus_arbitration_tb;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic mreset = 1'b0, pend = 1'b0, act = 1'b0, lock = 1'b0, term_n = 1'b1;
    logic need = 1'b0, done = 1'b0, won = 1'b0, abort = 1'b0, term = 1'b0;
    logic float_o, allowed, owner;
    logic last_owner = 1'b0, fault_seen = 1'b0;
    int errors = 0, n_checks = 0;
    logic exp_q[$];
    tba_link_if link();
    assign link.cycle_termination_ack_n = term_n;
    tba_arbiter u_tba_arbiter (.clock_in(clock_in), .reset_in(reset_in), .clock_enable_in(1'b1),
        .cycle_pending_in(pend), .cycle_active_in(act), .locked_active_in(lock),
        .bus_float_out(float_o), .cycle_allowed_out(allowed), .link(link.device));
    tba_master u_tba_master (.clock_in(clock_in), .reset_in(reset_in | mreset),
        .clock_enable_in(1'b1), .need_bus_in(need), .work_done_in(done),
        .priority_won_in(won), .abort_locked_in(abort), .check_term_in(term),
        .owner_out(owner), .link(link.master));
    tba_link_asserts u_tba_link_asserts (.clock_in(clock_in), .reset_in(reset_in),
        .bus_request_n(link.bus_request_n), .bus_grant_n(link.bus_grant_n),
        .grant_acknowledge_n(link.grant_acknowledge_n), .address_strobe_n(link.address_strobe_n),
        .cycle_termination_ack_n(link.cycle_termination_ack_n),
        .locked_cycle_n(link.locked_cycle_n), .bus_fault_n(link.bus_fault_n));
    initial forever #(tba_pkg::CLOCK_PERIOD_NS / 2) clock_in = ~clock_in;
    task automatic check(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // ownership monitor: each change of owner pops the oldest note
    // ---------------------------------------------------------------
    always @(posedge clock_in) begin
        if (link.bus_fault_n === 1'b0) fault_seen <= 1'b1;
        if (!reset_in && owner !== last_owner) begin
            last_owner = owner;
            n_checks++;
            if (exp_q.size() == 0 || exp_q.pop_front() !== owner) begin
                errors++;
                $display("[FAIL] %0t unexpected ownership change", $time);
            end
        end
    end
    // hold-off by pending cycle (defer) or by locked sequence (locked)
    task automatic episode(input bit defer, input bit locked);
        need <= 1'b1;
        won <= 1'b0;
        term <= 1'($urandom_range(1));
        pend <= defer;
        lock <= locked;
        abort <= 1'b0;
        exp_q.push_back(1'b1);
        exp_q.push_back(1'b0);
        @(posedge clock_in);
        abort <= locked;
        @(posedge clock_in);
        abort <= 1'b0;
        repeat (3) @(posedge clock_in);
        if (defer || locked) check(link.bus_grant_n, 1'b1, "grant while held off");
        act <= defer;
        term_n <= !defer;
        lock <= 1'b0;
        abort <= 1'b0;
        @(posedge clock_in);
        pend <= 1'b0;
        act <= 1'b0;
        term_n <= 1'b1;
        repeat ($urandom_range(3)) @(posedge clock_in);
        won <= 1'b1;
        for (int i = 0; i < 40 && owner !== 1'b1; i++) @(posedge clock_in);
        check(float_o, 1'b1, "buses not floated for owner");
        repeat ($urandom_range(6, 2)) @(posedge clock_in);
        done <= 1'b1;
        need <= 1'b0;
        @(posedge clock_in);
        done <= 1'b0;
        repeat (8) @(posedge clock_in);
        check(float_o, 1'b0, "buses still floated");
        check(allowed, 1'b1, "processor cycles still blocked");
    endtask
    initial begin
        void'($urandom(48));
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 4; i++) episode(1'b0, 1'b0);
        episode(1'b1, 1'b0);
        episode(1'b0, 1'b1);
        check(fault_seen, 1'b1, "no fault pulse on locked abort");
        need <= 1'b1;
        won <= 1'b0;
        repeat (5) @(posedge clock_in);
        check(link.bus_grant_n, 1'b0, "no grant before withdrawal");
        mreset <= 1'b1;
        need <= 1'b0;
        @(posedge clock_in);
        mreset <= 1'b0;
        repeat (8) @(posedge clock_in);
        check(link.bus_grant_n, 1'b1, "grant kept after withdrawal");
        check(allowed, 1'b1, "mastership lost after withdrawal");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
